// >>> hw/psw_pkg.sv
package psw_pkg;

   // clock rate and time units
   localparam int unsigned CLK_HZ      = 125_000_000;
   localparam int unsigned CYC_PER_MS  = CLK_HZ / 1000;

   // timebase tick every millisecond; all intervals count ticks
   localparam int unsigned TICK_CYCLES = CYC_PER_MS;

   // intervals in ms as printed
   localparam int unsigned PB_REJECT_MS   = 1;
   localparam int unsigned PB_DELAY_MS    = 4;
   localparam int unsigned PB_ACCEPT_MS   = 20;
   localparam int unsigned STRETCH_MS     = 250;
   localparam int unsigned WD_SHORT_MS    = 150;
   localparam int unsigned WD_MID_MS      = 600;
   localparam int unsigned WD_LONG_MS     = 1200;

   // tick-counter width covers the longest interval
   localparam int unsigned TCNT_W = 11;

   // three-state timeout select, decoded by the pad
   typedef enum logic [1:0] {
      PSW_TSEL_LOW   = 2'b00,
      PSW_TSEL_OPEN  = 2'b01,
      PSW_TSEL_HIGH  = 2'b10
   } psw_tsel_t;

   // reset sequencer states
   typedef enum logic [1:0] {
      PSW_ST_RUN     = 2'b00,
      PSW_ST_HOLD    = 2'b01,
      PSW_ST_STRETCH = 2'b10
   } psw_state_t;

endpackage

// >>> hw/psw_sync.sv
`timescale 1ns/10ps
module psw_sync
   import psw_pkg::*;
#(
   parameter int unsigned WIDTH = 1
) (
   input  wire logic             mclk_i,
   input  wire logic             sys_rst_i,
   input  wire logic [WIDTH-1:0] async_i,
   output logic      [WIDTH-1:0] sync_o
);
   typedef struct packed {
      logic [WIDTH-1:0] meta;
      logic [WIDTH-1:0] sync;
   } psw_sync_st_t;

   psw_sync_st_t s_q;
   psw_sync_st_t s_d;

   // first stage feeds only the second
   always_comb begin
      s_d.meta = async_i;
      s_d.sync = s_q.meta;
   end

   always_ff @(posedge mclk_i) begin
      if (sys_rst_i) begin
         s_q <= '0;
      end else begin
         s_q <= s_d;
      end
   end

   assign sync_o = s_q.sync;
endmodule

// >>> hw/psw_supervisor.sv
// Behaviour
// - pushbutton debounce: reject <1ms, accept >=20ms
// - timeout select: 150ms, 600ms, 1.2s
// - margin select picks 5% or 10% flag
// - reset on low supply, button, watchdog, power-up
// - active-low open-drain reset mirrors high output
// - hold resets while supply is low
// - 250ms in-tolerance stretch, dips restart it
// - button asserts only after pushbutton delay
// - 250ms stretch after button release
// - only strobe falling edges clear watchdog
// - missed strobe gives 250ms reset
// - repeat reset each timeout until strobed
`timescale 1ns/10ps
module psw_supervisor
   import psw_pkg::*;
#(
   parameter int unsigned TICK_DIV  = TICK_CYCLES,
   parameter int unsigned PB_DLY    = PB_DELAY_MS,
   parameter int unsigned STRETCH   = STRETCH_MS,
   parameter int unsigned WD_SHORT  = WD_SHORT_MS,
   parameter int unsigned WD_MID    = WD_MID_MS,
   parameter int unsigned WD_LONG   = WD_LONG_MS
) (
   input  wire logic       mclk_i,
   input  wire logic       sys_rst_i,
   input  wire logic       pushbutton_reset_n_i,
   input  wire logic [1:0] timeout_select_i,
   input  wire logic       supply_margin_select_i,
   input  wire logic       under_5pct_i,
   input  wire logic       under_10pct_i,
   input  wire logic       watchdog_kick_i,
   output logic            reset_o,
   output logic            reset_n_o,
   output logic            reset_n_oe_o
);
   localparam logic [TCNT_W-1:0] PB_DLY_T  = TCNT_W'(PB_DLY);
   localparam logic [TCNT_W-1:0] STR_T     = TCNT_W'(STRETCH);
   localparam logic [TCNT_W-1:0] WD_S_T    = TCNT_W'(WD_SHORT);
   localparam logic [TCNT_W-1:0] WD_M_T    = TCNT_W'(WD_MID);
   localparam logic [TCNT_W-1:0] WD_L_T    = TCNT_W'(WD_LONG);
   localparam int unsigned       DIV_W     = $clog2(TICK_DIV + 1);
   localparam logic [DIV_W-1:0]  DIV_LAST  = DIV_W'(TICK_DIV - 1);

   typedef struct packed {
      logic [DIV_W-1:0]  div;
      logic [TCNT_W-1:0] pb_cnt;
      logic              pb_on;
      logic [TCNT_W-1:0] wd_cnt;
      logic              kick_prev;
      logic [TCNT_W-1:0] str_cnt;
      psw_state_t        state;
      logic              rst;
   } psw_st_t;

   psw_st_t s_q;
   psw_st_t s_d;

   // reset image: every count clear, reset output already asserted
   localparam psw_st_t RST_ST = '{
      div:       '0,
      pb_cnt:    '0,
      pb_on:     1'b0,
      wd_cnt:    '0,
      kick_prev: 1'b0,
      str_cnt:   '0,
      state:     PSW_ST_STRETCH,
      rst:       1'b1
   };

   logic [3:0]        live_raw;
   logic [3:0]        live;
   logic [2:0]        strap_raw;
   logic [2:0]        strap;
   logic              pb_low;
   logic              kick;
   logic              under_v;
   logic [1:0]        tsel;
   logic              tick;
   logic [TCNT_W-1:0] wd_lim;
   logic              kick_fall;
   logic              wd_expired;
   logic              str_done;

   // button inverted so a high bit means pressed
   assign live_raw[3]    = ~pushbutton_reset_n_i;
   assign live_raw[2]    = watchdog_kick_i;
   assign live_raw[1]    = under_5pct_i;
   assign live_raw[0]    = under_10pct_i;
   // straps may settle a flop apart per bit; they do not move in use
   assign strap_raw[2]   = supply_margin_select_i;
   assign strap_raw[1:0] = timeout_select_i;

   // all outside levels pass two flops first
   psw_sync #(
      .WIDTH (4)
   ) u_sync_live (
      .mclk_i    (mclk_i),
      .sys_rst_i (sys_rst_i),
      .async_i   (live_raw),
      .sync_o    (live)
   );

   psw_sync #(
      .WIDTH (3)
   ) u_sync_strap (
      .mclk_i    (mclk_i),
      .sys_rst_i (sys_rst_i),
      .async_i   (strap_raw),
      .sync_o    (strap)
   );

   assign pb_low     = live[3];
   assign kick       = live[2];
   assign under_v    = strap[2] ? live[0] : live[1];
   // code 00 out of reset only lasts two cycles, inside the stretch
   assign tsel       = strap[1:0];
   assign tick       = (s_q.div == DIV_LAST);
   // a strobe counts only on its falling edge
   assign kick_fall  = s_q.kick_prev && !kick;
   // last tick of the selected timeout
   assign wd_expired = tick && (s_q.wd_cnt >= wd_lim - 1'b1);
   assign str_done   = tick && (s_q.str_cnt >= STR_T - 1'b1);

   always_comb begin
      unique case (psw_tsel_t'(tsel))
         PSW_TSEL_LOW:  wd_lim = WD_S_T;
         PSW_TSEL_OPEN: wd_lim = WD_M_T;
         PSW_TSEL_HIGH: wd_lim = WD_L_T;
         default:       wd_lim = WD_M_T;
      endcase
   end

   always_comb begin
      s_d = s_q;
      s_d.div = tick ? '0 : s_q.div + 1'b1;
      s_d.kick_prev = kick;

      // accept after pushbutton delay, never on the edge
      if (!pb_low) begin
         s_d.pb_cnt = '0;
         s_d.pb_on  = 1'b0;
      end else if (tick && !s_q.pb_on) begin
         if (s_q.pb_cnt >= PB_DLY_T - 1'b1) begin
            s_d.pb_on = 1'b1;
         end else begin
            s_d.pb_cnt = s_q.pb_cnt + 1'b1;
         end
      end

      unique case (s_q.state)
         PSW_ST_RUN: begin
            if (kick_fall) begin
               s_d.wd_cnt = '0;
            end else if (tick) begin
               s_d.wd_cnt = s_q.wd_cnt + 1'b1;
            end
            if (under_v || s_q.pb_on) begin
               s_d.state = PSW_ST_HOLD;
               s_d.rst   = 1'b1;
            end else if (wd_expired) begin
               s_d.state   = PSW_ST_STRETCH;
               s_d.str_cnt = '0;
               s_d.rst     = 1'b1;
            end
         end
         PSW_ST_HOLD: begin
            // held while low supply or button
            s_d.str_cnt = '0;
            if (!under_v && !s_q.pb_on) begin
               s_d.state = PSW_ST_STRETCH;
            end
         end
         PSW_ST_STRETCH: begin
            if (under_v || s_q.pb_on) begin
               s_d.state = PSW_ST_HOLD;
            end else if (tick) begin
               if (str_done) begin
                  // watchdog restarts, repeats if still silent
                  s_d.state  = PSW_ST_RUN;
                  s_d.rst    = 1'b0;
                  s_d.wd_cnt = '0;
               end else begin
                  s_d.str_cnt = s_q.str_cnt + 1'b1;
               end
            end
         end
         default: begin
            s_d.state = PSW_ST_HOLD;
         end
      endcase
   end

   always_ff @(posedge mclk_i) begin
      if (sys_rst_i) begin
         s_q <= RST_ST;
      end else begin
         s_q <= s_d;
      end
   end

   // single reset source for both pins
   assign reset_o      = s_q.rst;
   assign reset_n_o    = 1'b0;
   assign reset_n_oe_o = s_q.rst;
endmodule

// >>> testbench/psw_chk_sva.sv
`timescale 1ns/10ps
module psw_chk #(
   parameter int unsigned TICK_DIV = 2, PB_DLY = 4, STRETCH = 10,
   parameter int unsigned WD_SHORT = 15, WD_MID = 30, WD_LONG = 45
) (
   input wire logic       mclk_i,
   input wire logic       sys_rst_i,
   input wire logic       pushbutton_reset_n_i,
   input wire logic [1:0] timeout_select_i,
   input wire logic       supply_margin_select_i,
   input wire logic       under_5pct_i,
   input wire logic       under_10pct_i,
   input wire logic       watchdog_kick_i,
   input wire logic       reset_o,
   input wire logic       reset_n_o,
   input wire logic       reset_n_oe_o
);
   logic [15:0] hi_q, lo_q, kq_q;
   logic        kp_q;
   int          lim;
   always_comb lim = (timeout_select_i == 2'h0) ? WD_SHORT :
                     (timeout_select_i == 2'h2) ? WD_LONG : WD_MID;
   // counts restart at reset so no stale values reach the checks
   always_ff @(posedge mclk_i) begin
      hi_q <= (reset_o && !sys_rst_i) ? hi_q + 16'h1 : 16'h0;
      lo_q <= (pushbutton_reset_n_i || sys_rst_i) ? 16'h0 : lo_q + 16'h1;
      kp_q <= watchdog_kick_i;
      kq_q <= (sys_rst_i || reset_o || (kp_q && !watchdog_kick_i)) ? 16'h0 : kq_q + 16'h1;
   end
   default clocking @(posedge mclk_i); endclocking
   default disable iff (sys_rst_i);
   a_oe_mirror: assert property (reset_n_oe_o == reset_o)
      else $error("drain enable differs from reset");
   a_drain_low: assert property (reset_n_o == 1'b0)
      else $error("drain data not low");
   a_power_up: assert property ($fell(sys_rst_i) |-> reset_o [*8])
      else $error("no reset after power up");
   a_low_five: assert property ((!supply_margin_select_i && under_5pct_i) [*5] |-> reset_o)
      else $error("low supply at 5 pct not held");
   a_low_ten: assert property ((supply_margin_select_i && under_10pct_i) [*5] |-> reset_o)
      else $error("low supply at 10 pct not held");
   a_stretch_min: assert property ($fell(reset_o) |-> hi_q >= (STRETCH - 1) * TICK_DIV)
      else $error("reset pulse too short");
   a_button_take: assert property (lo_q == (PB_DLY + 1) * TICK_DIV + 5 |-> reset_o)
      else $error("held button not taken");
   a_wd_bound: assert property (kq_q <= (lim + 2) * TICK_DIV + 8)
      else $error("watchdog missed its timeout");
endmodule
bind psw_supervisor psw_chk #(
   .TICK_DIV (TICK_DIV),
   .PB_DLY   (PB_DLY),
   .STRETCH  (STRETCH),
   .WD_SHORT (WD_SHORT),
   .WD_MID   (WD_MID),
   .WD_LONG  (WD_LONG)
) u_psw_chk (
   .mclk_i                 (mclk_i),
   .sys_rst_i              (sys_rst_i),
   .pushbutton_reset_n_i   (pushbutton_reset_n_i),
   .timeout_select_i       (timeout_select_i),
   .supply_margin_select_i (supply_margin_select_i),
   .under_5pct_i           (under_5pct_i),
   .under_10pct_i          (under_10pct_i),
   .watchdog_kick_i        (watchdog_kick_i),
   .reset_o                (reset_o),
   .reset_n_o              (reset_n_o),
   .reset_n_oe_o           (reset_n_oe_o)
);

// >>> testbench/psw_host.sv
`timescale 1ns/10ps
module psw_host (
   input  wire logic       mclk_i,
   input  wire logic       reset_i,
   input  wire logic [7:0] period_i,
   output logic            kick_o
);
   logic [7:0] cnt_q = 8'h0;
   initial kick_o = 1'b0;
   // toggle kick line; halted while in reset, period zero leaves it static
   always @(posedge mclk_i) begin
      if (reset_i || period_i == 8'h0) cnt_q <= 8'h0;
      else if (cnt_q >= period_i) begin
         cnt_q <= 8'h0;
         kick_o <= #1 ~kick_o;
      end else cnt_q <= cnt_q + 8'h1;
   end
endmodule

// >>> testbench/psw_supervisor_bench.sv
`timescale 1ns/10ps
`define CHK(a, b) begin check_count++; if ((a) !== (b)) begin fail_count++; \
   $display("ERROR %0t: got %0h want %0h", $time, a, b); end end
module psw_supervisor_bench;
   localparam int TD = 2, SR = 10;
   logic       mclk_i = 1'b0, sys_rst_i = 1'b1, pb_n = 1'b1, msel = 1'b0;
   logic       u5 = 1'b0, u10 = 1'b0, rst_o, rst_n_o, oe, kick, hit;
   logic [1:0] tsel = 2'h0;
   logic [7:0] per = 8'h4;
   int         fail_count = 0, check_count = 0, seed = 32'h526b, n;
   always #4 mclk_i = ~mclk_i;
   psw_supervisor #(.TICK_DIV(TD), .PB_DLY(4), .STRETCH(SR), .WD_SHORT(15), .WD_MID(30),
      .WD_LONG(45)) u_psw_supervisor (.mclk_i(mclk_i), .sys_rst_i(sys_rst_i),
      .pushbutton_reset_n_i(pb_n), .timeout_select_i(tsel), .supply_margin_select_i(msel),
      .under_5pct_i(u5), .under_10pct_i(u10), .watchdog_kick_i(kick), .reset_o(rst_o),
      .reset_n_o(rst_n_o), .reset_n_oe_o(oe));
   psw_host u_psw_host (.mclk_i(mclk_i), .reset_i(rst_o), .period_i(per), .kick_o(kick));
   function automatic logic in_rng(int v, int lo, int hi);
      return v >= lo && v <= hi;
   endfunction
   function automatic int wd(int s);
      return s == 0 ? 15 : s == 2 ? 45 : 30;
   endfunction
   task automatic test_done;
      $display("checks %0d errors %0d", check_count, fail_count);
      if (fail_count == 0 && check_count > 0) $display("bench passed");
      else $display("bench failed");
      $finish;
   endtask
   task automatic tk(int c);
      repeat (c) @(posedge mclk_i);
      #1;
   endtask
   task automatic quiet(int c);
      hit = 1'b0;
      repeat (c) begin tk(1); hit |= rst_o; end
   endtask
   // bounded wait for a reset level, cycles taken left in n
   task automatic wt(logic v, int mx);
      n = 0;
      while (rst_o !== v && n < mx) begin tk(1); n++; end
      if (rst_o !== v) begin
         fail_count++;
         $display("ERROR %0t: wait ran out", $time);
         test_done();
      end
   endtask
   initial begin
      tk(5);
      sys_rst_i = 1'b0;
      wt(0, 60); `CHK(in_rng(n, (SR - 1) * TD, (SR + 1) * TD + 6), 1'b1)
      repeat (4) begin
         per = 8'(2 + {$random(seed)} % 8);
         tsel = 2'($random(seed));
         quiet(150); `CHK(hit, 1'b0)
      end
      for (int i = 0; i < 4; i++) begin
         tsel = 2'(i);
         per = 8'h2;
         tk(40);
         per = 8'h0;
         wt(1, 200); `CHK(in_rng(n, wd(i) * TD - 2 * TD - 6, wd(i) * TD + 2 * TD + 8), 1'b1)
         wt(0, 60); `CHK(in_rng(n, (SR - 1) * TD, (SR + 1) * TD + 6), 1'b1)
         wt(1, 200); `CHK(in_rng(n, wd(i) * TD - TD - 2, wd(i) * TD + 2 * TD + 8), 1'b1)
         wt(0, 60);
      end
      // toggles every 20 cycles, falls every 40: a rise must not restart it
      tsel = 2'h0;
      per = 8'h13;
      wt(1, 70); `CHK(in_rng(n, 26, 60), 1'b1)
      wt(0, 60);
      tsel = 2'h0;
      per = 8'h2;
      msel = 1'b1;
      u5 = 1'b1;
      quiet(30); `CHK(hit, 1'b0)
      u10 = 1'b1;
      tk(6);
      repeat (20 + {$random(seed)} % 30) begin tk(1); `CHK(rst_o, 1'b1) end
      {u5, u10} = 2'h0;
      tk(10);
      {u5, u10} = 2'h3;
      tk(1);
      {u5, u10} = 2'h0;
      wt(0, 60); `CHK(in_rng(n, (SR - 1) * TD, (SR + 1) * TD + 6), 1'b1)
      msel = 1'b0;
      u5 = 1'b1;
      tk(6); `CHK(rst_o, 1'b1)
      `CHK({oe, rst_n_o}, 2'h2)
      u5 = 1'b0;
      wt(0, 60);
      pb_n = 1'b0;
      tk(1);
      pb_n = 1'b1;
      quiet(30); `CHK(hit, 1'b0)
      pb_n = 1'b0;
      tk(4); `CHK(rst_o, 1'b0)
      // hold button the full accept time
      tk(36); `CHK(rst_o, 1'b1)
      pb_n = 1'b1;
      wt(0, 60); `CHK(in_rng(n, (SR - 1) * TD, (SR + 1) * TD + 6), 1'b1)
      `CHK({oe, rst_n_o}, 2'h0)
      test_done();
   end
endmodule
